// [tb/tasc_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// link controller model
// ----------------------------------------
module tasc_host (
    // clock
    input wire logic ref_clk,
    // link
    output logic serial_clk,
    output logic serial_frame_enable,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n
);
    logic drv_en;
    logic drv_bit;
    logic last_bit = 1'b0;
    // released line flips each cycle so a stale level never passes
    assign sdio_in = !sdio_oe_n ? sdio_out : (drv_en ? drv_bit : !last_bit);
    always @(posedge ref_clk) last_bit <= sdio_in;
    initial begin
        serial_clk = 1'b0;
        serial_frame_enable = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // nbits below 16 drops the frame early
    task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata, input int nbits,
                        output logic [7:0] rdata);
        logic [15:0] sh;
        logic rd;
        sh = {addr, wdata};
        rd = (addr == 8'hFF);
        rdata = 8'h00;
        serial_frame_enable = 1'b1;
        wait_n(4);
        for (int i = 15; i >= 16 - nbits; i--) begin
            serial_clk = 1'b0;
            drv_en = !(rd && i < 8);
            drv_bit = sh[i];
            wait_n(8);
            serial_clk = 1'b1;
            if (i < 8) rdata[i] = sdio_in;
            wait_n(8);
        end
        serial_clk = 1'b0;
        drv_en = 1'b0;
        wait_n(4);
        serial_frame_enable = 1'b0;
        wait_n(4);
    endtask
endmodule
`default_nettype wire

// [tb/tasc_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module tasc_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic serial_frame_enable,
    input wire logic sdio_oe_n,
    input wire logic freeze_pin,
    input wire logic write_pattern_pin,
    input wire logic hold_pin_role,
    input wire logic [1:0] vga_source_sel,
    input wire logic manual_gain,
    input wire logic [3:0] fixed_gain_code,
    input wire logic [3:0] live_gain_code,
    input wire logic [1:0] filter_corner_code,
    input wire logic write_input_style,
    input wire logic toggle_function_on,
    input wire logic write_polarity,
    input wire logic [6:0] write_current_code
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_CTRL_QUIET: assert property (!serial_frame_enable [*6] |->
        $stable(write_current_code) && $stable(filter_corner_code)) else $error("entry moved");
    AST_OE_RELEASE: assert property (!serial_frame_enable [*5] |-> sdio_oe_n)
        else $error("line driven outside frame");
    AST_VGA_FORCED: assert property ((hold_pin_role && !freeze_pin) [*5] |->
        vga_source_sel == 2'b00) else $error("servo not forced");
    AST_MANUAL_GAIN: assert property ((manual_gain && $stable(fixed_gain_code)) [*3] |->
        live_gain_code == fixed_gain_code) else $error("fixed gain not applied");
    AST_HOLD_MAX: assert property ((!manual_gain && hold_pin_role && !freeze_pin) [*6] |->
        live_gain_code == 4'hF) else $error("servo gain not max");
    AST_FROZEN: assert property ((!manual_gain && !hold_pin_role && !freeze_pin) [*5] |=>
        $stable(live_gain_code)) else $error("gain not frozen");
    AST_TOGGLE_FN: assert property ($stable(write_input_style) [*2] |->
        toggle_function_on != write_input_style) else $error("toggle function wrong");
    AST_POL_FALL: assert property (!write_input_style [*4] ##0 $fell(write_pattern_pin) |->
        ##[1:6] $changed(write_polarity)) else $error("no flip on fall");
    AST_POL_LEVEL: assert property (write_input_style [*4] ##0 $changed(write_pattern_pin) |->
        ##[1:6] $changed(write_polarity)) else $error("no flip on change");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_n, serial_clk, serial_frame_enable, sdio_in, sdio_out, sdio_oe_n;
    logic freeze_pin, write_pattern_pin, level_too_large, level_too_small;
    logic low_5v_event, low_12v_event, write_fault_event;
    logic [1:0] filter_corner_code, bias_mode_code, vga_source_sel, loop_source_sel;
    logic [1:0] preamp_gain_code;
    logic current_source_on, read_chain_on, reference_on, hold_pin_role, highpass_on;
    logic gain_range_boost, manual_gain, write_input_style, toggle_function_on;
    logic write_polarity, sense_range_double;
    logic [3:0] fixed_gain_code, live_gain_code;
    logic [4:0] bias_level_code;
    logic [6:0] write_current_code, sense_current_code;
    int errors = 0;
    int cmp_count = 0;
    // ----------------------------------------
    // design and link controller
    // ----------------------------------------
    // short up step keeps the ramp test brief
    tasc_top #(.AGC_UP_CYCLES(20)) dut_u (.*);
    tasc_host host_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic check_all(input logic [7:0] v);
        check("ctrl0", {filter_corner_code, bias_mode_code, current_source_on, read_chain_on,
            reference_on}, v[6:0]);
        check("ctrl1", {hold_pin_role, highpass_on, loop_source_sel, preamp_gain_code},
            {v[7:6], v[3:0]});
        check("vga", vga_source_sel, v[5:4]);
        check("ctrl2", {gain_range_boost, manual_gain, fixed_gain_code}, v[5:0]);
        check("ctrl3", bias_level_code, v[4:0]);
        check("ctrl4", {write_input_style, toggle_function_on, write_current_code},
            {v[7], !v[7], v[6:0]});
        check("ctrl5", {sense_range_double, sense_current_code}, v);
        if (v[4]) check("live", live_gain_code, v[3:0]);
    endtask
    task automatic t_regs;
        logic [7:0] r;
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v = 8'(8'h55 * k);
            for (int a = 0; a < 6; a++) host_u.xfer(a[7:0], v, 16, r);
            check_all(v);
        end
        host_u.xfer(8'h06, 8'h00, 16, r);
        host_u.xfer(8'h80, 8'h00, 16, r);
        host_u.xfer(8'h04, 8'h00, 12, r);
        check_all(8'hFF);
    endtask
    task automatic t_status;
        logic [7:0] r;
        host_u.xfer(8'h02, 8'h1A, 16, r);
        level_too_large = 1'b1;
        low_5v_event = 1'b1;
        write_fault_event = 1'b1;
        wait_n(4);
        low_5v_event = 1'b0;
        write_fault_event = 1'b0;
        host_u.xfer(8'hFF, 8'h00, 16, r);
        check("status", r, 8'hAE);
        level_too_large = 1'b0;
        low_12v_event = 1'b1;
        wait_n(4);
        low_12v_event = 1'b0;
        host_u.xfer(8'hFF, 8'h00, 16, r);
        check("status", r, 8'hA1);
        host_u.xfer(8'hFF, 8'h00, 16, r);
        check("status", r, 8'hA0);
    endtask
    task automatic t_pol;
        logic [7:0] r;
        logic p;
        for (int m = 0; m < 2; m++) begin
            host_u.xfer(8'h04, {m[0], 7'h00}, 16, r);
            p = write_polarity;
            write_pattern_pin = 1'b1;
            wait_n(10);
            check("pol rise", write_polarity, p ^ m[0]);
            write_pattern_pin = 1'b0;
            wait_n(10);
            check("pol fall", write_polarity, !p ^ m[0]);
        end
    endtask
    task automatic t_agc;
        logic [7:0] r;
        host_u.xfer(8'h02, 8'h00, 16, r);
        host_u.xfer(8'h01, 8'hB0, 16, r);
        freeze_pin = 1'b0;
        wait_n(8);
        check("servo gain", live_gain_code, 4'hF);
        check("servo src", vga_source_sel, 2'b00);
        freeze_pin = 1'b1;
        level_too_large = 1'b1;
        wait_n(8);
        check("vga src", vga_source_sel, 2'b11);
        wait_n(1400);
        check("gain down", live_gain_code, 4'hE);
        level_too_large = 1'b0;
        host_u.xfer(8'h01, 8'h00, 16, r);
        freeze_pin = 1'b0;
        level_too_small = 1'b1;
        wait_n(600);
        check("frozen", live_gain_code, 4'hE);
        freeze_pin = 1'b1;
        wait_n(400);
        check("gain up", live_gain_code, 4'hF);
        level_too_small = 1'b0;
    endtask
    initial begin
        rst_n = 1'b0;
        freeze_pin = 1'b1;
        write_pattern_pin = 1'b0;
        level_too_large = 1'b0;
        level_too_small = 1'b0;
        low_5v_event = 1'b0;
        low_12v_event = 1'b0;
        write_fault_event = 1'b0;
        wait_n(6);
        rst_n = 1'b1;
        wait_n(8);
        check_all(8'h00);
        t_regs();
        t_status();
        t_pol();
        t_agc();
        tally_and_finish();
    end
    // about 12k cycles expected; 40k means a hang
    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end
endmodule
bind tasc_top tasc_props chk_u (.*);
`default_nettype wire

// [verilog/tasc_agc.sv]
`timescale 1ns/100ps
`default_nettype none
module tasc_agc #(
    parameter int UP_CYCLES = tasc_pkg::AGC_UP_STEP_CYCLES,
    parameter int DOWN_CYCLES = tasc_pkg::AGC_DOWN_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic hold_max,
    input wire logic manual,
    input wire logic [3:0] fixed_code,
    // level detector
    input wire logic too_large,
    input wire logic too_small,
    // result
    output logic [3:0] gain
);
    logic [31:0] tick;
    logic [31:0] limit;

    // slow climb, fast fall
    assign limit = too_large ? 32'(DOWN_CYCLES - 1) : 32'(UP_CYCLES - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= '0;
        end else if (!run || manual || (!too_large && !too_small) || tick >= limit) begin
            tick <= '0;
        end else begin
            tick <= tick + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gain <= tasc_pkg::GAIN_MIN;
        end else if (manual) begin
            gain <= fixed_code;
        end else if (hold_max) begin
            gain <= tasc_pkg::GAIN_MAX;
        end else if (run && tick >= limit) begin
            if (too_large && gain != tasc_pkg::GAIN_MIN) begin
                gain <= gain - 4'h1;
            end else if (too_small && !too_large && gain != tasc_pkg::GAIN_MAX) begin
                gain <= gain + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/tasc_pkg.sv]
`default_nettype none
package tasc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int AGC_RAMP_UP_US = 10000;
    localparam int AGC_RAMP_DOWN_US = 200;
    localparam int AGC_STEPS = 15;
    // longest times: round down, never below one cycle
    localparam int AGC_UP_STEP_CYCLES = (AGC_RAMP_UP_US * CLK_MHZ) / AGC_STEPS;
    localparam int AGC_DOWN_STEP_CYCLES = (AGC_RAMP_DOWN_US * CLK_MHZ) / AGC_STEPS;
    localparam int STATUS_CLK_RATIO = 16;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // serial map
    // ------------------------------------------------------------
    localparam int NUM_CTRL = 6;
    localparam logic [7:0] ADDR_ENABLE_AND_FILTER_CTRL = 8'h00;
    localparam logic [7:0] ADDR_READ_PATH_SELECT_CTRL = 8'h01;
    localparam logic [7:0] ADDR_GAIN_CTRL = 8'h02;
    localparam logic [7:0] ADDR_BIAS_LEVEL_CTRL = 8'h03;
    localparam logic [7:0] ADDR_WRITE_CURRENT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SENSE_CURRENT_CTRL = 8'h05;
    localparam logic [7:0] ADDR_DEVICE_STATUS = 8'hFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FILTER_LSB = 5;
    localparam int BIAS_MODE_LSB = 3;
    localparam int CUR_SRC_BIT = 2;
    localparam int READ_CHAIN_BIT = 1;
    localparam int REF_BIT = 0;
    localparam int ROLE_BIT = 7;
    localparam int HIGHPASS_BIT = 6;
    localparam int VGA_SRC_LSB = 4;
    localparam int LOOP_SRC_LSB = 2;
    localparam int PREAMP_LSB = 0;
    localparam int BOOST_BIT = 5;
    localparam int MANUAL_BIT = 4;
    localparam int FIXED_LSB = 0;
    localparam int BIAS_LEVEL_LSB = 0;
    localparam int STYLE_BIT = 7;
    localparam int WCODE_LSB = 0;
    localparam int SDOUBLE_BIT = 7;
    localparam int SCODE_LSB = 0;
    localparam int ST_GAIN_LSB = 4;
    localparam int ST_DIR_BIT = 3;
    localparam int ST_5V_BIT = 2;
    localparam int ST_WFAULT_BIT = 1;
    localparam int ST_12V_BIT = 0;
    localparam logic [3:0] GAIN_MAX = 4'hF;
    localparam logic [3:0] GAIN_MIN = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VGA_SERVO = 2'b00,
        VGA_PREAMP = 2'b01,
        VGA_BIAS_M10 = 2'b10,
        VGA_BIAS_M4 = 2'b11
    } tasc_vga_src_e;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_ADDR = 3'b001,
        LINK_DATA = 3'b010,
        LINK_READ = 3'b011,
        LINK_DONE = 3'b100
    } tasc_link_state_e;

endpackage
`default_nettype wire

// [verilog/tasc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module tasc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// [verilog/tasc_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - transfer is 8-bit address, 8-bit data
// - address FF returns status byte instead
// - general clock times status, steps AGC
// - six control entries, spare bits ignored
// - filter corner code sets both corners
// - bias mode code: off or three ranges
// - bias level code times 45 mV
// - enables for reference, read, sense; highpass
// - role bit: freeze is hold or select
// - vga source code, servo forced when held
// - loop source code selects feedback input
// - preamp gain code selects gain
// - AGC run, freeze or max gain
// - fixed gain code in 1 dB steps
// - write input style toggle or level
// - seven-bit current codes, five-bit bias DAC
// - write polarity flips on pattern edges
// - status byte layout gain, hint, faults
// - fault flags sticky until status read
// - sense range doubling bit
module tasc_top #(
    parameter int AGC_UP_CYCLES = tasc_pkg::AGC_UP_STEP_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial link
    input wire logic serial_clk,
    input wire logic serial_frame_enable,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    // analogue side inputs
    input wire logic freeze_pin,
    input wire logic write_pattern_pin,
    input wire logic level_too_large,
    input wire logic level_too_small,
    input wire logic low_5v_event,
    input wire logic low_12v_event,
    input wire logic write_fault_event,
    // enable and filter
    output logic [1:0] filter_corner_code,
    output logic [1:0] bias_mode_code,
    output logic current_source_on,
    output logic read_chain_on,
    output logic reference_on,
    // read path
    output logic hold_pin_role,
    output logic highpass_on,
    output logic [1:0] vga_source_sel,
    output logic [1:0] loop_source_sel,
    output logic [1:0] preamp_gain_code,
    // gain
    output logic gain_range_boost,
    output logic manual_gain,
    output logic [3:0] fixed_gain_code,
    output logic [3:0] live_gain_code,
    // bias, write and sense DACs
    output logic [4:0] bias_level_code,
    output logic write_input_style,
    output logic toggle_function_on,
    output logic write_polarity,
    output logic [6:0] write_current_code,
    output logic sense_range_double,
    output logic [6:0] sense_current_code
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // the bit clock is only a sampled level here; a stopped general
    // clock simply freezes everything, so only the bit clock is free to stop
    logic [10:0] raw_in;
    logic [10:0] sync_in;
    logic sclk_s;
    logic frame_s;
    logic sdi_s;
    logic freeze_s;
    logic pattern_s;
    logic large_s;
    logic small_s;
    logic low5_s;
    logic low12_s;
    logic wfault_s;

    assign raw_in = {serial_clk, serial_frame_enable, sdio_in, freeze_pin,
        write_pattern_pin, level_too_large, level_too_small, low_5v_event,
        low_12v_event, write_fault_event, 1'b0};
    assign {sclk_s, frame_s, sdi_s, freeze_s, pattern_s, large_s, small_s,
        low5_s, low12_s, wfault_s} = sync_in[10:1];

    tasc_sync #(
        .WIDTH(11)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .d(raw_in),
        .q(sync_in)
    );

    // ------------------------------------------------------------
    // link edge detection
    // ------------------------------------------------------------
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // edges found by the general clock, hence the 16x ratio demand
    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;

    // ------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------
    tasc_pkg::tasc_link_state_e state;
    tasc_pkg::tasc_link_state_e next_state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] addr;
    logic [7:0] rx_byte;
    logic byte_done;
    logic status_read;
    logic write_strobe;

    assign rx_byte = {rx_shift[6:0], sdi_s};
    assign byte_done = sclk_rise && bit_cnt == tasc_pkg::LAST_BIT;
    assign status_read = state == tasc_pkg::LINK_ADDR && byte_done
        && rx_byte == tasc_pkg::ADDR_DEVICE_STATUS;
    assign write_strobe = state == tasc_pkg::LINK_DATA && byte_done;

    always_comb begin
        next_state = state;
        case (state)
            tasc_pkg::LINK_IDLE: begin
                if (frame_s) begin
                    next_state = tasc_pkg::LINK_ADDR;
                end
            end
            tasc_pkg::LINK_ADDR: begin
                if (status_read) begin
                    next_state = tasc_pkg::LINK_READ;
                end else if (byte_done) begin
                    next_state = tasc_pkg::LINK_DATA;
                end
            end
            tasc_pkg::LINK_DATA: begin
                if (byte_done) begin
                    next_state = tasc_pkg::LINK_DONE;
                end
            end
            tasc_pkg::LINK_READ: begin
                if (byte_done) begin
                    next_state = tasc_pkg::LINK_DONE;
                end
            end
            default: begin
                next_state = tasc_pkg::LINK_DONE;
            end
        endcase
        // a dropped frame ends any transfer
        if (!frame_s) begin
            next_state = tasc_pkg::LINK_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= tasc_pkg::LINK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
        end else if (!frame_s || state == tasc_pkg::LINK_IDLE) begin
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_shift <= rx_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            addr <= 8'h00;
        end else if (state == tasc_pkg::LINK_ADDR && byte_done) begin
            addr <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // control entries
    // ------------------------------------------------------------
    logic [7:0] ctrl [tasc_pkg::NUM_CTRL];

    generate
        for (genvar i = 0; i < tasc_pkg::NUM_CTRL; i++) begin : g_ctrl
            always_ff @(posedge ref_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    ctrl[i] <= tasc_pkg::CTRL_RESET;
                end else if (write_strobe && addr == 8'(i)) begin
                    ctrl[i] <= rx_byte;
                end
            end
        end
    endgenerate

    // fields; unassigned bits are stored but drive nothing
    assign filter_corner_code = ctrl[0][tasc_pkg::FILTER_LSB +: 2];
    assign bias_mode_code = ctrl[0][tasc_pkg::BIAS_MODE_LSB +: 2];
    assign current_source_on = ctrl[0][tasc_pkg::CUR_SRC_BIT];
    assign read_chain_on = ctrl[0][tasc_pkg::READ_CHAIN_BIT];
    assign reference_on = ctrl[0][tasc_pkg::REF_BIT];
    assign hold_pin_role = ctrl[1][tasc_pkg::ROLE_BIT];
    assign highpass_on = ctrl[1][tasc_pkg::HIGHPASS_BIT];
    assign loop_source_sel = ctrl[1][tasc_pkg::LOOP_SRC_LSB +: 2];
    assign preamp_gain_code = ctrl[1][tasc_pkg::PREAMP_LSB +: 2];
    assign gain_range_boost = ctrl[2][tasc_pkg::BOOST_BIT];
    assign manual_gain = ctrl[2][tasc_pkg::MANUAL_BIT];
    assign fixed_gain_code = ctrl[2][tasc_pkg::FIXED_LSB +: 4];
    assign bias_level_code = ctrl[3][tasc_pkg::BIAS_LEVEL_LSB +: 5];
    assign write_input_style = ctrl[4][tasc_pkg::STYLE_BIT];
    assign write_current_code = ctrl[4][tasc_pkg::WCODE_LSB +: 7];
    assign sense_range_double = ctrl[5][tasc_pkg::SDOUBLE_BIT];
    assign sense_current_code = ctrl[5][tasc_pkg::SCODE_LSB +: 7];

    // ------------------------------------------------------------
    // read path select
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vga_source_sel <= tasc_pkg::VGA_SERVO;
        end else if (hold_pin_role && !freeze_s) begin
            vga_source_sel <= tasc_pkg::VGA_SERVO;
        end else begin
            vga_source_sel <= ctrl[1][tasc_pkg::VGA_SRC_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // AGC
    // ------------------------------------------------------------
    logic agc_run;
    logic agc_hold_max;

    assign agc_run = freeze_s;
    assign agc_hold_max = !freeze_s && hold_pin_role;

    tasc_agc #(
        .UP_CYCLES(AGC_UP_CYCLES),
        .DOWN_CYCLES(tasc_pkg::AGC_DOWN_STEP_CYCLES)
    ) u_agc (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .run(agc_run),
        .hold_max(agc_hold_max),
        .manual(manual_gain),
        .fixed_code(fixed_gain_code),
        .too_large(large_s),
        .too_small(small_s),
        .gain(live_gain_code)
    );

    // ------------------------------------------------------------
    // write pattern polarity
    // ------------------------------------------------------------
    logic pattern_d;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pattern_d <= 1'b0;
            write_polarity <= 1'b0;
            toggle_function_on <= 1'b1;
        end else begin
            pattern_d <= pattern_s;
            toggle_function_on <= !write_input_style;
            if (write_input_style && pattern_s != pattern_d) begin
                write_polarity <= !write_polarity;
            end else if (!write_input_style && !pattern_s && pattern_d) begin
                write_polarity <= !write_polarity;
            end
        end
    end

    // ------------------------------------------------------------
    // sticky fault flags
    // ------------------------------------------------------------
    logic flag_5v;
    logic flag_12v;
    logic flag_wfault;
    logic [7:0] status_byte;

    // a new fault in the clearing cycle survives the clear
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flag_5v <= 1'b0;
            flag_12v <= 1'b0;
            flag_wfault <= 1'b0;
        end else begin
            flag_5v <= (flag_5v && !status_read) || low5_s;
            flag_12v <= (flag_12v && !status_read) || low12_s;
            flag_wfault <= (flag_wfault && !status_read) || wfault_s;
        end
    end

    always_comb begin
        status_byte = 8'h00;
        status_byte[tasc_pkg::ST_GAIN_LSB +: 4] = live_gain_code;
        status_byte[tasc_pkg::ST_DIR_BIT] = large_s;
        status_byte[tasc_pkg::ST_5V_BIT] = flag_5v;
        status_byte[tasc_pkg::ST_WFAULT_BIT] = flag_wfault;
        status_byte[tasc_pkg::ST_12V_BIT] = flag_12v;
    end

    // ------------------------------------------------------------
    // status return
    // ------------------------------------------------------------
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_shift <= 8'h00;
            tx_cnt <= 4'h0;
            sdio_out <= 1'b0;
            sdio_oe_n <= 1'b1;
        end else if (status_read) begin
            tx_shift <= status_byte;
            tx_cnt <= 4'h0;
        end else if (state != tasc_pkg::LINK_READ) begin
            // released once the byte is out or the frame drops
            sdio_oe_n <= 1'b1;
            tx_cnt <= 4'h0;
        end else if (sclk_fall && tx_cnt != 4'h8) begin
            sdio_out <= tx_shift[7];
            sdio_oe_n <= 1'b0;
            tx_shift <= {tx_shift[6:0], 1'b0};
            tx_cnt <= tx_cnt + 4'h1;
        end
    end

endmodule
`default_nettype wire
